// File: hdl/pas_shutdown.v
// PWM auto-shutdown control with AXI4-Lite register access.
// Assumes PWM waveforms and a period-start pulse from the PWM timebase on core_clk;
// comparator outputs and the interrupt pin are asynchronous and are synchronised here.
`timescale 1ns/100ps
`include "pas_regs.vh"

module pas_shutdown (
   core_clk,
   resetn,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready,
   pwm_in_a,
   pwm_in_b,
   pwm_in_c,
   pwm_in_d,
   period_start,
   comparator_one,
   comparator_two,
   int_pin,
   pwm_out_a,
   pwm_out_a_oe,
   pwm_out_b,
   pwm_out_b_oe,
   pwm_out_c,
   pwm_out_c_oe,
   pwm_out_d,
   pwm_out_d_oe,
   shutdown_active
);
   input  wire                   core_clk;
   input  wire                   resetn;
   input  wire [`PAS_ADDR_W-1:0] s_axi_awaddr;
   input  wire                   s_axi_awvalid;
   output wire                   s_axi_awready;
   input  wire [31:0]            s_axi_wdata;
   input  wire [3:0]             s_axi_wstrb;
   input  wire                   s_axi_wvalid;
   output wire                   s_axi_wready;
   output reg  [1:0]             s_axi_bresp;
   output reg                    s_axi_bvalid;
   input  wire                   s_axi_bready;
   input  wire [`PAS_ADDR_W-1:0] s_axi_araddr;
   input  wire                   s_axi_arvalid;
   output wire                   s_axi_arready;
   output reg  [31:0]            s_axi_rdata;
   output reg  [1:0]             s_axi_rresp;
   output reg                    s_axi_rvalid;
   input  wire                   s_axi_rready;
   input  wire                   pwm_in_a;
   input  wire                   pwm_in_b;
   input  wire                   pwm_in_c;
   input  wire                   pwm_in_d;
   input  wire                   period_start;
   input  wire                   comparator_one;
   input  wire                   comparator_two;
   input  wire                   int_pin;
   output reg                    pwm_out_a;
   output reg                    pwm_out_a_oe;
   output reg                    pwm_out_b;
   output reg                    pwm_out_b_oe;
   output reg                    pwm_out_c;
   output reg                    pwm_out_c_oe;
   output reg                    pwm_out_d;
   output reg                    pwm_out_d_oe;
   output wire                   shutdown_active;

   localparam [`PAS_ADDR_W-1:0] ADDR_CTRL      = `PAS_ADDR_CTRL;
   localparam [`PAS_ADDR_W-1:0] ADDR_STATUS    = `PAS_ADDR_STATUS;
   localparam [`PAS_ADDR_W-1:0] ADDR_PWM_IN    = `PAS_ADDR_PWM_IN;
   localparam [7:0]             CTRL_RESET_VAL = `PAS_CTRL_RESET;

   // Synchronised trip sources
   wire [2:0] trip_sync;
   wire       cmp1_s;
   wire       cmp2_s;
   wire       pin_s;

   pas_sync2 #(
      .WIDTH (3)
   ) u_sync (
      .core_clk (core_clk),
      .resetn   (resetn),
      .async_in ({int_pin, comparator_two, comparator_one}),
      .sync_out (trip_sync)
   );

   assign cmp1_s = trip_sync[0];
   assign cmp2_s = trip_sync[1];
   assign pin_s  = trip_sync[2];

   // Control register and output hold state
   reg        shutdown_event_flag_reg;
   reg [2:0]  shutdown_source_select_reg;
   reg [1:0]  pair_ac_shutdown_state_reg;
   reg [1:0]  pair_bd_shutdown_state_reg;
   reg        hold_reg;
   reg        hold_next;

   // Level-sensitive trip decode
   wire shutdown_cond;
   assign shutdown_cond =
      (shutdown_source_select_reg[`PAS_SRC_C1_BIT] & cmp1_s) |
      (shutdown_source_select_reg[`PAS_SRC_C2_BIT] & cmp2_s) |
      (shutdown_source_select_reg[`PAS_SRC_PIN_BIT] & ~pin_s);

   // AXI write channel: take address and data in either order
   reg                   aw_held_reg;
   reg [`PAS_ADDR_W-1:0] aw_addr_reg;
   reg                   w_held_reg;
   reg [31:0]            w_data_reg;
   reg [3:0]             w_strb_reg;
   wire                  wr_fire;
   wire                  wr_ctrl;

   assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
   assign wr_fire       = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   assign wr_ctrl       = wr_fire & (aw_addr_reg[`PAS_ADDR_W-1:2] == ADDR_CTRL[`PAS_ADDR_W-1:2]) & w_strb_reg[0];

   always @(posedge core_clk) begin
      if (!resetn) begin
         aw_held_reg  <= 1'b0;
         aw_addr_reg  <= {`PAS_ADDR_W{1'b0}};
         w_held_reg   <= 1'b0;
         w_data_reg   <= 32'h0000_0000;
         w_strb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `PAS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_reg[`PAS_ADDR_W-1:2] == ADDR_CTRL[`PAS_ADDR_W-1:2] ||
                aw_addr_reg[`PAS_ADDR_W-1:2] == ADDR_STATUS[`PAS_ADDR_W-1:2] ||
                aw_addr_reg[`PAS_ADDR_W-1:2] == ADDR_PWM_IN[`PAS_ADDR_W-1:2])
               s_axi_bresp <= `PAS_RESP_OKAY;
            else
               s_axi_bresp <= `PAS_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control register; hardware set of the flag beats any software write
   always @(posedge core_clk) begin
      if (!resetn) begin
         shutdown_event_flag_reg    <= CTRL_RESET_VAL[`PAS_FLAG_BIT];
         shutdown_source_select_reg <= CTRL_RESET_VAL[`PAS_SRC_HI:`PAS_SRC_LO];
         pair_ac_shutdown_state_reg <= CTRL_RESET_VAL[`PAS_AC_HI:`PAS_AC_LO];
         pair_bd_shutdown_state_reg <= CTRL_RESET_VAL[`PAS_BD_HI:`PAS_BD_LO];
      end else begin
         if (wr_ctrl) begin
            shutdown_source_select_reg <= w_data_reg[`PAS_SRC_HI:`PAS_SRC_LO];
            pair_ac_shutdown_state_reg <= w_data_reg[`PAS_AC_HI:`PAS_AC_LO];
            pair_bd_shutdown_state_reg <= w_data_reg[`PAS_BD_HI:`PAS_BD_LO];
            if (!shutdown_cond)
               shutdown_event_flag_reg <= w_data_reg[`PAS_FLAG_BIT];
         end
         if (shutdown_cond)
            shutdown_event_flag_reg <= 1'b1;
      end
   end

   // Output hold: enters at once with the flag, leaves only at a period start
   always @* begin
      hold_next = hold_reg;
      if (shutdown_event_flag_reg || shutdown_cond)
         hold_next = 1'b1;
      else if (period_start)
         hold_next = 1'b0;
   end

   always @(posedge core_clk) begin
      if (!resetn)
         hold_reg <= 1'b0;
      else
         hold_reg <= hold_next;
   end

   assign shutdown_active = hold_reg;

   // Registered pin drivers
   always @(posedge core_clk) begin
      if (!resetn) begin
         pwm_out_a    <= 1'b0;
         pwm_out_b    <= 1'b0;
         pwm_out_c    <= 1'b0;
         pwm_out_d    <= 1'b0;
         pwm_out_a_oe <= 1'b1;
         pwm_out_b_oe <= 1'b1;
         pwm_out_c_oe <= 1'b1;
         pwm_out_d_oe <= 1'b1;
      end else if (hold_next) begin
         pwm_out_a    <= (pair_ac_shutdown_state_reg == `PAS_ST_HIGH);
         pwm_out_c    <= (pair_ac_shutdown_state_reg == `PAS_ST_HIGH);
         pwm_out_a_oe <= ~pair_ac_shutdown_state_reg[`PAS_ST_HIZ_BIT];
         pwm_out_c_oe <= ~pair_ac_shutdown_state_reg[`PAS_ST_HIZ_BIT];
         pwm_out_b    <= (pair_bd_shutdown_state_reg == `PAS_ST_HIGH);
         pwm_out_d    <= (pair_bd_shutdown_state_reg == `PAS_ST_HIGH);
         pwm_out_b_oe <= ~pair_bd_shutdown_state_reg[`PAS_ST_HIZ_BIT];
         pwm_out_d_oe <= ~pair_bd_shutdown_state_reg[`PAS_ST_HIZ_BIT];
      end else begin
         pwm_out_a    <= pwm_in_a;
         pwm_out_b    <= pwm_in_b;
         pwm_out_c    <= pwm_in_c;
         pwm_out_d    <= pwm_in_d;
         pwm_out_a_oe <= 1'b1;
         pwm_out_b_oe <= 1'b1;
         pwm_out_c_oe <= 1'b1;
         pwm_out_d_oe <= 1'b1;
      end
   end

   // AXI read channel
   reg [31:0] rd_word;
   reg        rd_ok;
   assign s_axi_arready = ~s_axi_rvalid;

   always @* begin
      rd_word = 32'h0000_0000;
      rd_ok   = 1'b1;
      case (s_axi_araddr[`PAS_ADDR_W-1:2])
         ADDR_CTRL[`PAS_ADDR_W-1:2]: begin
            rd_word[`PAS_FLAG_BIT]          = shutdown_event_flag_reg;
            rd_word[`PAS_SRC_HI:`PAS_SRC_LO] = shutdown_source_select_reg;
            rd_word[`PAS_AC_HI:`PAS_AC_LO]   = pair_ac_shutdown_state_reg;
            rd_word[`PAS_BD_HI:`PAS_BD_LO]   = pair_bd_shutdown_state_reg;
         end
         ADDR_STATUS[`PAS_ADDR_W-1:2]: begin
            rd_word[`PAS_STAT_COND_BIT] = shutdown_cond;
            rd_word[`PAS_STAT_HOLD_BIT] = hold_reg;
            rd_word[`PAS_STAT_C1_BIT]   = cmp1_s;
            rd_word[`PAS_STAT_C2_BIT]   = cmp2_s;
            rd_word[`PAS_STAT_PIN_BIT]  = pin_s;
         end
         ADDR_PWM_IN[`PAS_ADDR_W-1:2]: begin
            rd_word[3:0] = {pwm_in_d, pwm_in_c, pwm_in_b, pwm_in_a};
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `PAS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_ok ? `PAS_RESP_OKAY : `PAS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // pas_shutdown

// File: include/pas_regs.vh
// Register map and field layout of the PWM auto-shutdown control block.
// Included by the design files; definitions only.
`ifndef PAS_REGS_VH
`define PAS_REGS_VH

// Byte addresses on the AXI4-Lite bus
`define PAS_ADDR_CTRL       8'h00
`define PAS_ADDR_STATUS     8'h04
`define PAS_ADDR_PWM_IN     8'h08
`define PAS_ADDR_W          8

// Control register fields
`define PAS_CTRL_RESET      8'h00
`define PAS_FLAG_BIT        7
`define PAS_SRC_HI          6
`define PAS_SRC_LO          4
`define PAS_AC_HI           3
`define PAS_AC_LO           2
`define PAS_BD_HI           1
`define PAS_BD_LO           0

// Source select encodings
`define PAS_SRC_C1_BIT      0
`define PAS_SRC_C2_BIT      1
`define PAS_SRC_PIN_BIT     2

// Shutdown pin state encodings
`define PAS_ST_LOW          2'h0
`define PAS_ST_HIGH         2'h1
`define PAS_ST_HIZ_BIT      1

// Status register fields
`define PAS_STAT_COND_BIT   0
`define PAS_STAT_HOLD_BIT   1
`define PAS_STAT_C1_BIT     2
`define PAS_STAT_C2_BIT     3
`define PAS_STAT_PIN_BIT    4

// AXI responses
`define PAS_RESP_OKAY       2'h0
`define PAS_RESP_SLVERR     2'h2

`endif

// File: hdl/pas_sync2.v
// Two flip-flop synchroniser for asynchronous level inputs.
// Assumes the input is a slow level from a pin or analog comparator.
`timescale 1ns/100ps

module pas_sync2 #(
   parameter WIDTH = 1
) (
   core_clk,
   resetn,
   async_in,
   sync_out
);
   input  wire             core_clk;
   input  wire             resetn;
   input  wire [WIDTH-1:0] async_in;
   output wire [WIDTH-1:0] sync_out;

   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;

   always @(posedge core_clk) begin
      if (!resetn) begin
         meta_reg <= {WIDTH{1'b0}};
         sync_reg <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;

endmodule // pas_sync2

// File: sim/pas_props.sv
// Port-level checks for the PWM auto-shutdown block.
// Bound to pas_shutdown; sees only its ports.
`timescale 1ns/100ps
module pas_props (
   input wire       core_clk,
   input wire       resetn,
   input wire       period_start,
   input wire       pwm_in_a,
   input wire       pwm_out_a,
   input wire       pwm_out_a_oe,
   input wire       pwm_out_b,
   input wire       pwm_out_b_oe,
   input wire       pwm_out_c,
   input wire       pwm_out_c_oe,
   input wire       pwm_out_d,
   input wire       pwm_out_d_oe,
   input wire       shutdown_active,
   input wire       s_axi_bvalid,
   input wire       s_axi_bready,
   input wire [1:0] s_axi_bresp
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   a_pair_ac: assert property (shutdown_active |->
      pwm_out_a == pwm_out_c && pwm_out_a_oe == pwm_out_c_oe) else $error("pair a c differs");
   a_pair_bd: assert property (shutdown_active |->
      pwm_out_b == pwm_out_d && pwm_out_b_oe == pwm_out_d_oe) else $error("pair b d differs");
   a_normal_follow: assert property (!shutdown_active && $past(resetn) |->
      pwm_out_a == $past(pwm_in_a) && pwm_out_a_oe) else $error("output a not following pwm");
   a_hiz_only_held: assert property (!pwm_out_b_oe |->
      shutdown_active && !pwm_out_b) else $error("output b released outside shutdown");
   a_release_period: assert property ($fell(shutdown_active) && $past(resetn) |->
      $past(period_start)) else $error("release off period start");
   a_hold_until_period: assert property (shutdown_active && !period_start |=>
      shutdown_active) else $error("shutdown dropped mid period");
   a_state_steady: assert property (shutdown_active && $past(shutdown_active) &&
      !s_axi_bvalid && !$past(s_axi_bvalid) |-> $stable(pwm_out_a) && $stable(pwm_out_a_oe))
      else $error("shutdown state moved");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");

   c_enter: cover property ($rose(shutdown_active));
   c_leave: cover property ($fell(shutdown_active));
   c_hiz: cover property (shutdown_active && !pwm_out_a_oe);
endmodule // pas_props

bind pas_shutdown pas_props u_props (.core_clk, .resetn, .period_start, .pwm_in_a, .pwm_out_a, .pwm_out_a_oe,
   .pwm_out_b, .pwm_out_b_oe, .pwm_out_c, .pwm_out_c_oe, .pwm_out_d, .pwm_out_d_oe, .shutdown_active,
   .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);

// File: sim/pas_power_stage.sv
// Power switching stage fed by the four PWM pins.
// Gate inputs carry pull-downs, so a released pin reads low.
`timescale 1ns/100ps
module pas_power_stage (
   input  wire pwm_out_a,
   input  wire pwm_out_a_oe,
   input  wire pwm_out_b,
   input  wire pwm_out_b_oe,
   input  wire pwm_out_c,
   input  wire pwm_out_c_oe,
   input  wire pwm_out_d,
   input  wire pwm_out_d_oe,
   output wire gate_a,
   output wire gate_b,
   output wire gate_c,
   output wire gate_d
);
   assign gate_a = pwm_out_a_oe & pwm_out_a;
   assign gate_b = pwm_out_b_oe & pwm_out_b;
   assign gate_c = pwm_out_c_oe & pwm_out_c;
   assign gate_d = pwm_out_d_oe & pwm_out_d;
endmodule // pas_power_stage

// File: sim/tb_pwm_auto_shutdown_control.sv
// Self-checking bench for the PWM auto-shutdown block.
// Drives AXI4-Lite, trip sources and a free-running PWM pattern.
`timescale 1ns/100ps
`include "pas_regs.vh"
module tb_pwm_auto_shutdown_control;
   reg         core_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   reg  [7:0]  s_axi_awaddr, s_axi_araddr;
   reg  [31:0] s_axi_wdata, rd;
   reg  [3:0]  s_axi_wstrb, pwm_in;
   reg  [1:0]  rs;
   reg         period_start, comparator_one, comparator_two, int_pin;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, shutdown_active;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire        pwm_out_a, pwm_out_a_oe, pwm_out_b, pwm_out_b_oe, pwm_out_c, pwm_out_c_oe, pwm_out_d, pwm_out_d_oe;
   wire        gate_a, gate_b, gate_c, gate_d;
   reg         bready_late;
   integer     n_mismatch, checks_done, s, k;

   pas_shutdown DUT (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_in_a(pwm_in[0]),
      .pwm_in_b(pwm_in[1]), .pwm_in_c(pwm_in[2]), .pwm_in_d(pwm_in[3]), .period_start, .comparator_one,
      .comparator_two, .int_pin, .pwm_out_a, .pwm_out_a_oe, .pwm_out_b, .pwm_out_b_oe, .pwm_out_c, .pwm_out_c_oe,
      .pwm_out_d, .pwm_out_d_oe, .shutdown_active);
   pas_power_stage u_stage (.pwm_out_a, .pwm_out_a_oe, .pwm_out_b, .pwm_out_b_oe, .pwm_out_c, .pwm_out_c_oe,
      .pwm_out_d, .pwm_out_d_oe, .gate_a, .gate_b, .gate_c, .gate_d);

   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) pwm_in <= pwm_in + 4'h1;

   task chk(input [31:0] g, input [31:0] e);
      begin
         checks_done = checks_done + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask

   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge core_clk);
         s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
         s_axi_bready <= !bready_late;
         do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
         end while (!s_axi_bvalid);
         // Late acceptance: response must stand until taken
         if (bready_late) begin
            s_axi_bready <= 1'b1;
            @(posedge core_clk);
         end
         rs = s_axi_bresp;
         s_axi_bready <= 1'b0;
      end
   endtask

   task rd_reg(input [7:0] a);
      begin
         @(posedge core_clk);
         s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
         do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (!s_axi_rvalid);
         rd = s_axi_rdata; rs = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask

   task src(input c1, input c2, input p);
      begin
         @(posedge core_clk);
         comparator_one <= c1; comparator_two <= c2; int_pin <= p;
         repeat (5) @(posedge core_clk);
      end
   endtask

   task pulse;
      begin
         @(posedge core_clk) period_start <= 1'b1;
         @(posedge core_clk) period_start <= 1'b0;
      end
   endtask

   // Remove sources, clear the flag, then restart at a period start
   task release_all;
      begin
         src(1'b0, 1'b0, 1'b1);
         wr(`PAS_ADDR_CTRL, 32'h0);
         pulse;
         repeat (2) @(posedge core_clk);
         chk(shutdown_active, 1'b0);
      end
   endtask

   task t_reset;
      begin
         rd_reg(`PAS_ADDR_CTRL);
         chk(rs, `PAS_RESP_OKAY);
         chk(rd, {24'h0, `PAS_CTRL_RESET});
         rd_reg(8'h0c);
         chk(rs, `PAS_RESP_SLVERR);
         chk(rd, 32'h0);
         bready_late = 1'b1;
         wr(8'h0c, 32'hff);
         bready_late = 1'b0;
         chk(rs, `PAS_RESP_SLVERR);
         chk({shutdown_active, pwm_out_a_oe, pwm_out_b_oe, pwm_out_c_oe, pwm_out_d_oe}, 5'h0f);
         chk({pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a}, {pwm_in - 4'h1});
         rd_reg(`PAS_ADDR_PWM_IN);
         chk(rs, `PAS_RESP_OKAY);
         chk(rd, {pwm_in - 4'h1});
         $display("test reset done");
      end
   endtask

   task t_decode;
      begin
         for (s = 0; s < 8; s = s + 1) begin
            for (k = 0; k < 4; k = k + 1) begin
               wr(`PAS_ADDR_CTRL, {25'h0, s[2:0], 4'h0});
               src(k == 1, k == 2, k != 3);
               chk(shutdown_active, (k == 1 && s[0]) || (k == 2 && s[1]) || (k == 3 && s[2]));
               rd_reg(`PAS_ADDR_CTRL);
               chk(rd[7], (k == 1 && s[0]) || (k == 2 && s[1]) || (k == 3 && s[2]));
               release_all;
            end
         end
         $display("test decode done");
      end
   endtask

   task t_states;
      begin
         for (s = 0; s < 4; s = s + 1) begin
            wr(`PAS_ADDR_CTRL, {24'h0, 4'h1, s[1:0], ~s[1:0]});
            src(1'b1, 1'b0, 1'b1);
            chk({pwm_out_a, pwm_out_a_oe, pwm_out_c, pwm_out_c_oe}, {2{s == 1, !s[1]}});
            chk({pwm_out_b, pwm_out_b_oe, pwm_out_d, pwm_out_d_oe}, {2{s == 2, s[1]}});
            chk({gate_a, gate_c, gate_b, gate_d}, {s == 1, s == 1, s == 2, s == 2});
            release_all;
         end
         $display("test states done");
      end
   endtask

   task t_level;
      begin
         wr(`PAS_ADDR_CTRL, 32'h40);
         src(1'b0, 1'b0, 1'b0);
         pulse;
         pulse;
         chk(shutdown_active, 1'b1);
         rd_reg(`PAS_ADDR_STATUS);
         chk(rd, (32'h1 << `PAS_STAT_COND_BIT) | (32'h1 << `PAS_STAT_HOLD_BIT));
         wr(`PAS_ADDR_CTRL, 32'h40);
         rd_reg(`PAS_ADDR_CTRL);
         chk(rd, 32'hc0);
         src(1'b0, 1'b0, 1'b1);
         chk(shutdown_active, 1'b1);
         wr(`PAS_ADDR_CTRL, 32'h0);
         repeat (6) @(posedge core_clk);
         chk(shutdown_active, 1'b1);
         rd_reg(`PAS_ADDR_CTRL);
         chk(rd, 32'h0);
         pulse;
         @(posedge core_clk);
         chk(shutdown_active, 1'b0);
         $display("test level done");
      end
   endtask

   task finish_test;
      begin
         $display("checks %0d mismatches %0d", checks_done, n_mismatch);
         if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch = n_mismatch + 1;
      finish_test;
   end

   initial begin
      n_mismatch = 0; checks_done = 0; core_clk = 1'b0; resetn = 1'b0; pwm_in = 4'h0; bready_late = 1'b0;
      s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf;
      s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
      period_start = 1'b0; comparator_one = 1'b0; comparator_two = 1'b0; int_pin = 1'b1;
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      t_reset;
      t_decode;
      t_states;
      t_level;
      finish_test;
   end
endmodule // tb_pwm_auto_shutdown_control
